// file: hdl/sea_pkg.sv
// shared types and constants for the storage element array
package sea_pkg;

  // element count default
  localparam int SEA_WIDTH_DEF = 4;

  // state shown by every element while reset is applied
  localparam logic SEA_Q_RST  = 1'b0;
  localparam logic SEA_QN_RST = 1'b1;

  // shared controls, sampled together from the pins
  typedef struct packed {
    logic set_n;
    logic async_zero_n;
    logic flop_clk;
    logic rise_edge_enable;
    logic fall_edge_enable;
    logic latch_gate;
  } sea_ctrl_t;

  localparam int SEA_CTRL_W = $bits(sea_ctrl_t);

  // idle controls: both asynchronous controls inactive, clock and gate low
  localparam sea_ctrl_t SEA_CTRL_IDLE = '{
    set_n:            1'b1,
    async_zero_n:     1'b1,
    flop_clk:         1'b0,
    rise_edge_enable: 1'b0,
    fall_edge_enable: 1'b0,
    latch_gate:       1'b0
  };

  // output pair forced by the asynchronous controls, else the normal pair
  function automatic logic [1:0] sea_pair(input logic set_n, input logic zero_n, input logic [1:0] norm);
    logic [1:0] res;
    res = norm;
    if (!set_n && !zero_n) begin
      res = 2'b11;
    end else if (!set_n) begin
      res = 2'b10;
    end else if (!zero_n) begin
      res = 2'b01;
    end
    return res;
  endfunction

endpackage

// file: hdl/sea_sync.sv
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module sea_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // pins in, synchronised copy out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta     <= pin_in;
      sync_out <= meta;
    end
  end

endmodule

// file: hdl/sea_top.sv
// dual-edge flip-flop and gated latch arrays sampled on the system clock
// Functional notes
// - single set or clear forces outputs
// - set and clear together drive both high
// - D flop loads on enabled edge
// - JK hold, clear, set, toggle on edge
// - element count parameter, shared controls
// - SR latch and D latch variants
// - steady clock or no enable holds
// - D latch transparent on gate high
// - SR latch table, both high unstable
`timescale 1ns/1ps
module sea_top
  import sea_pkg::*;
#(
  parameter int N = SEA_WIDTH_DEF
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  // shared controls
  input  wire logic         async_one_n,
  input  wire logic         async_zero_n,
  input  wire logic         flop_clk,
  input  wire logic         rise_edge_enable,
  input  wire logic         fall_edge_enable,
  input  wire logic         latch_gate,
  // dual-edge D flops
  input  wire logic [N-1:0] dual_edge_d_flop_d,
  output logic      [N-1:0] dual_edge_d_flop_q,
  output logic      [N-1:0] dual_edge_d_flop_q_n,
  // dual-edge JK flops
  input  wire logic [N-1:0] dual_edge_toggle_flop_j,
  input  wire logic [N-1:0] dual_edge_toggle_flop_k,
  output logic      [N-1:0] dual_edge_toggle_flop_q,
  output logic      [N-1:0] dual_edge_toggle_flop_q_n,
  // set-reset latches
  input  wire logic [N-1:0] set_reset_latch_s,
  input  wire logic [N-1:0] set_reset_latch_r,
  output logic      [N-1:0] set_reset_latch_q,
  output logic      [N-1:0] set_reset_latch_q_n,
  // D latches
  input  wire logic [N-1:0] transparent_data_latch_d,
  output logic      [N-1:0] transparent_data_latch_q,
  output logic      [N-1:0] transparent_data_latch_q_n
);

  logic            rst_meta;
  logic            rst_n;
  sea_ctrl_t       ctrl_pin;
  sea_ctrl_t       ctrl;
  logic [6*N-1:0]  data_pin;
  logic [6*N-1:0]  data_s;
  logic [N-1:0]    dd_s;
  logic [N-1:0]    jj_s;
  logic [N-1:0]    kk_s;
  logic [N-1:0]    ss_s;
  logic [N-1:0]    rr_s;
  logic [N-1:0]    dl_s;
  logic            clk_prev;
  logic            rise;
  logic            fall;
  logic            edge_load;
  logic [N-1:0]    next_dq;
  logic [N-1:0]    next_dqn;
  logic [N-1:0]    next_jq;
  logic [N-1:0]    next_jqn;
  logic [N-1:0]    next_sq;
  logic [N-1:0]    next_sqn;
  logic [N-1:0]    next_lq;
  logic [N-1:0]    next_lqn;

  // reset release through two flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  assign ctrl_pin = '{
    set_n:            async_one_n,
    async_zero_n:     async_zero_n,
    flop_clk:         flop_clk,
    rise_edge_enable: rise_edge_enable,
    fall_edge_enable: fall_edge_enable,
    latch_gate:       latch_gate
  };

  // data and controls share one sync depth so a pin edge stays aligned with its data
  assign data_pin = {dual_edge_d_flop_d, dual_edge_toggle_flop_j, dual_edge_toggle_flop_k,
                     set_reset_latch_s, set_reset_latch_r, transparent_data_latch_d};

  sea_sync #(
    .W       (SEA_CTRL_W),
    .RST_VAL (SEA_CTRL_IDLE)
  ) u_ctrl_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (ctrl_pin),
    .sync_out (ctrl)
  );

  sea_sync #(
    .W       (6*N),
    .RST_VAL ('0)
  ) u_data_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin_in   (data_pin),
    .sync_out (data_s)
  );

  assign {dd_s, jj_s, kk_s, ss_s, rr_s, dl_s} = data_s;

  // previous clock level; reset matches the sync reset so no phantom edge appears
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= SEA_CTRL_IDLE.flop_clk;
    end else begin
      clk_prev <= ctrl.flop_clk;
    end
  end

  assign rise      = ctrl.flop_clk & ~clk_prev;
  assign fall      = ~ctrl.flop_clk & clk_prev;
  // steady level or both enables low: no load
  assign edge_load = (rise & ctrl.rise_edge_enable) | (fall & ctrl.fall_edge_enable);

  // per-element next values; all arrays share the same controls
  always_comb begin
    next_dq  = dual_edge_d_flop_q;
    next_dqn = dual_edge_d_flop_q_n;
    next_jq  = dual_edge_toggle_flop_q;
    next_jqn = dual_edge_toggle_flop_q_n;
    next_sq  = set_reset_latch_q;
    next_sqn = set_reset_latch_q_n;
    next_lq  = transparent_data_latch_q;
    next_lqn = transparent_data_latch_q_n;
    for (int i = 0; i < N; i++) begin
      // D flop
      {next_dq[i], next_dqn[i]} = sea_pair(ctrl.set_n, ctrl.async_zero_n,
        edge_load ? {dd_s[i], ~dd_s[i]} : {dual_edge_d_flop_q[i], dual_edge_d_flop_q_n[i]});
      // JK flop
      if (edge_load) begin
        case ({jj_s[i], kk_s[i]})
          2'b01:   {next_jq[i], next_jqn[i]} = 2'b01;
          2'b10:   {next_jq[i], next_jqn[i]} = 2'b10;
          2'b11:   {next_jq[i], next_jqn[i]} = {~dual_edge_toggle_flop_q[i], dual_edge_toggle_flop_q[i]};
          default: {next_jq[i], next_jqn[i]} = {dual_edge_toggle_flop_q[i], dual_edge_toggle_flop_q_n[i]};
        endcase
      end
      {next_jq[i], next_jqn[i]} = sea_pair(ctrl.set_n, ctrl.async_zero_n, {next_jq[i], next_jqn[i]});
      // SR latch; both inputs high is the unstable both-high pair
      if (ctrl.latch_gate) begin
        case ({ss_s[i], rr_s[i]})
          2'b01:   {next_sq[i], next_sqn[i]} = 2'b01;
          2'b10:   {next_sq[i], next_sqn[i]} = 2'b10;
          2'b11:   {next_sq[i], next_sqn[i]} = 2'b11;
          default: {next_sq[i], next_sqn[i]} = {set_reset_latch_q[i], set_reset_latch_q_n[i]};
        endcase
      end
      {next_sq[i], next_sqn[i]} = sea_pair(ctrl.set_n, ctrl.async_zero_n, {next_sq[i], next_sqn[i]});
      // D latch
      {next_lq[i], next_lqn[i]} = sea_pair(ctrl.set_n, ctrl.async_zero_n,
        ctrl.latch_gate ? {dl_s[i], ~dl_s[i]}
                        : {transparent_data_latch_q[i], transparent_data_latch_q_n[i]});
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dual_edge_d_flop_q   <= {N{SEA_Q_RST}};
      dual_edge_d_flop_q_n <= {N{SEA_QN_RST}};
    end else begin
      dual_edge_d_flop_q   <= next_dq;
      dual_edge_d_flop_q_n <= next_dqn;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dual_edge_toggle_flop_q   <= {N{SEA_Q_RST}};
      dual_edge_toggle_flop_q_n <= {N{SEA_QN_RST}};
    end else begin
      dual_edge_toggle_flop_q   <= next_jq;
      dual_edge_toggle_flop_q_n <= next_jqn;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      set_reset_latch_q   <= {N{SEA_Q_RST}};
      set_reset_latch_q_n <= {N{SEA_QN_RST}};
    end else begin
      set_reset_latch_q   <= next_sq;
      set_reset_latch_q_n <= next_sqn;
    end
  end

  // a true latch would glitch-pass data; here the gate is sampled, trading latency for timing safety
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transparent_data_latch_q   <= {N{SEA_Q_RST}};
      transparent_data_latch_q_n <= {N{SEA_QN_RST}};
    end else begin
      transparent_data_latch_q   <= next_lq;
      transparent_data_latch_q_n <= next_lqn;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  logic ctrl_ok;
  assign ctrl_ok = ctrl.set_n & ctrl.async_zero_n;

  a_set_forces_one: assert property (
    (!ctrl.set_n && ctrl.async_zero_n) |=> (dual_edge_d_flop_q == '1 && dual_edge_d_flop_q_n == '0
      && dual_edge_toggle_flop_q == '1 && set_reset_latch_q == '1 && transparent_data_latch_q_n == '0))
    else $error("set did not force ones");

  a_clear_forces_zero: assert property (
    (ctrl.set_n && !ctrl.async_zero_n) |=> (dual_edge_d_flop_q == '0 && dual_edge_toggle_flop_q_n == '1
      && set_reset_latch_q_n == '1 && transparent_data_latch_q == '0))
    else $error("clear did not force zeros");

  a_both_low_high: assert property (
    (!ctrl.set_n && !ctrl.async_zero_n) |=> ((dual_edge_d_flop_q & dual_edge_d_flop_q_n
      & dual_edge_toggle_flop_q & dual_edge_toggle_flop_q_n & set_reset_latch_q & set_reset_latch_q_n
      & transparent_data_latch_q & transparent_data_latch_q_n) == '1))
    else $error("set and clear together did not drive both high");

  a_d_rise_load: assert property (
    (ctrl_ok && rise && ctrl.rise_edge_enable) |=>
      (dual_edge_d_flop_q == $past(dd_s) && dual_edge_d_flop_q_n == ~$past(dd_s)))
    else $error("D flop missed rising load");

  a_d_fall_load: assert property (
    (ctrl_ok && fall && ctrl.fall_edge_enable) |=> (dual_edge_d_flop_q == $past(dd_s)))
    else $error("D flop missed falling load");

  a_jk_update: assert property (
    (ctrl_ok && edge_load) |=> (dual_edge_toggle_flop_q ==
      (($past(jj_s) & ~$past(dual_edge_toggle_flop_q)) | (~$past(kk_s) & $past(dual_edge_toggle_flop_q)))))
    else $error("JK flop wrong update");

  a_flop_hold: assert property (
    (ctrl_ok && !edge_load) |=> ($stable(dual_edge_d_flop_q) && $stable(dual_edge_toggle_flop_q)
      && $stable(dual_edge_d_flop_q_n)))
    else $error("flop changed without qualified edge");

  a_dlatch_pass: assert property (
    (ctrl_ok && ctrl.latch_gate) |=> (transparent_data_latch_q == $past(dl_s)
      && transparent_data_latch_q_n == ~$past(dl_s)))
    else $error("D latch not transparent");

  a_latch_hold: assert property (
    (ctrl_ok && !ctrl.latch_gate) |=> ($stable(transparent_data_latch_q) && $stable(set_reset_latch_q)
      && $stable(set_reset_latch_q_n)))
    else $error("latch changed with gate low");

  a_sr_table: assert property (
    (ctrl_ok && ctrl.latch_gate) |=>
      (set_reset_latch_q == ($past(ss_s) | ($past(set_reset_latch_q) & ~$past(rr_s)))
      && set_reset_latch_q_n == ($past(rr_s) | ($past(set_reset_latch_q_n) & ~$past(ss_s)))))
    else $error("SR latch wrong response");

endmodule

// file: testbench/dual_edge_flop_and_latch_array_tb.sv
// self-checking bench for the dual-edge flop and gated latch arrays
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module dual_edge_flop_and_latch_array_tb;
  import sea_pkg::*;
  localparam int N = 4;
  logic            clk_sys;
  logic            resetn;
  sea_ctrl_t       c;
  sea_ctrl_t       pc;
  logic [N-1:0]    d, j, k, s, r, pd, pj, pk, ps, pr, jq;
  logic [N-1:0]    dq, dqn, jkq, jkqn, srq, srqn, dlq, dlqn;
  int              n_errors;
  int              num_checks;

  sea_pins #(.N(N)) pins (.clk_sys(clk_sys), .ctrl(pc), .d(pd), .j(pj), .k(pk), .s(ps), .r(pr));

  sea_top #(.N(N)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .async_one_n(pc.set_n), .async_zero_n(pc.async_zero_n),
    .flop_clk(pc.flop_clk), .rise_edge_enable(pc.rise_edge_enable),
    .fall_edge_enable(pc.fall_edge_enable), .latch_gate(pc.latch_gate),
    .dual_edge_d_flop_d(pd), .dual_edge_d_flop_q(dq), .dual_edge_d_flop_q_n(dqn),
    .dual_edge_toggle_flop_j(pj), .dual_edge_toggle_flop_k(pk),
    .dual_edge_toggle_flop_q(jkq), .dual_edge_toggle_flop_q_n(jkqn),
    .set_reset_latch_s(ps), .set_reset_latch_r(pr), .set_reset_latch_q(srq), .set_reset_latch_q_n(srqn),
    .transparent_data_latch_d(pd), .transparent_data_latch_q(dlq), .transparent_data_latch_q_n(dlqn));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic go();
    pins.put(c, d, j, k, s, r);
  endtask

  // same pair expected on all four arrays
  task automatic chk_all(input logic [N-1:0] eq, input logic [N-1:0] eqn);
    `CHK("d flop q", eq, dq)
    `CHK("d flop q_n", eqn, dqn)
    `CHK("jk flop q", eq, jkq)
    `CHK("jk flop q_n", eqn, jkqn)
    `CHK("sr latch q", eq, srq)
    `CHK("sr latch q_n", eqn, srqn)
    `CHK("d latch q", eq, dlq)
    `CHK("d latch q_n", eqn, dlqn)
  endtask

  task automatic t_async();
    chk_all({N{SEA_Q_RST}}, {N{SEA_QN_RST}});
    c.set_n = 1'b0;
    go();
    chk_all(4'hf, 4'h0);
    c.set_n = 1'b1;
    c.async_zero_n = 1'b0;
    go();
    chk_all(4'h0, 4'hf);
    c.set_n = 1'b0;
    go();
    chk_all(4'hf, 4'hf);
    c.set_n = 1'b1;
    go();
    chk_all(4'h0, 4'hf);
    c.async_zero_n = 1'b1;
    go();
  endtask

  task automatic t_dflop();
    d = 4'ha;
    c.rise_edge_enable = 1'b1;
    go();
    c.flop_clk = 1'b1;
    go();
    `CHK("d flop rise q", 4'ha, dq)
    `CHK("d flop rise q_n", 4'h5, dqn)
    `CHK("jk hold q", 4'h0, jkq)
    d = 4'h5;
    go();
    `CHK("d flop high hold", 4'ha, dq)
    c.flop_clk = 1'b0;
    go();
    `CHK("d flop fall no enable", 4'ha, dq)
    c.rise_edge_enable = 1'b0;
    c.flop_clk = 1'b1;
    go();
    `CHK("d flop no enables", 4'ha, dq)
    c.fall_edge_enable = 1'b1;
    go();
    c.flop_clk = 1'b0;
    go();
    `CHK("d flop fall q", 4'h5, dq)
    `CHK("d flop fall q_n", 4'ha, dqn)
  endtask

  task automatic t_jk();
    c.set_n = 1'b0;
    go();
    c.set_n = 1'b1;
    c.rise_edge_enable = 1'b1;
    j = 4'hc;
    k = 4'ha;
    go();
    jq = 4'hf;
    // toggle, set, clear and hold side by side, over a rise and a fall
    for (int i = 0; i < 2; i++) begin
      c.flop_clk = ~c.flop_clk;
      go();
      jq = (j & ~jq) | (~k & jq);
      `CHK("jk q", jq, jkq)
      `CHK("jk q_n", ~jq, jkqn)
      `CHK("d flop q", d, dq)
    end
  endtask

  task automatic t_latch();
    d = 4'h6;
    s = 4'hc;
    r = 4'ha;
    c.latch_gate = 1'b1;
    go();
    `CHK("d latch open q", 4'h6, dlq)
    `CHK("d latch open q_n", 4'h9, dlqn)
    `CHK("sr latch q", 4'hd, srq)
    `CHK("sr latch q_n", 4'ha, srqn)
    c.latch_gate = 1'b0;
    go();
    d = 4'h9;
    s = 4'h0;
    r = 4'hf;
    go();
    `CHK("d latch closed q", 4'h6, dlq)
    `CHK("sr latch closed q", 4'hd, srq)
    c.latch_gate = 1'b1;
    go();
    `CHK("d latch reopened q", 4'h9, dlq)
    `CHK("sr latch reset q", 4'h0, srq)
    `CHK("sr latch reset q_n", 4'hf, srqn)
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // whole run is about 125 cycles; the watchdog ends it after 3000
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    n_errors = 0;
    num_checks = 0;
    c = SEA_CTRL_IDLE;
    {d, j, k, s, r, jq} = '0;
    resetn = 1'b0;
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    resetn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    t_async();
    t_dflop();
    t_jk();
    t_latch();
    tally_and_finish();
  end
endmodule

// file: testbench/sea_pins.sv
// pin driver model of the logic that surrounds the storage array
`timescale 1ns/1ps
module sea_pins
  import sea_pkg::*;
#(
  parameter int N = SEA_WIDTH_DEF
) (
  // clock
  input  wire logic         clk_sys,
  // pins towards the array
  output sea_ctrl_t         ctrl,
  output logic      [N-1:0] d,
  output logic      [N-1:0] j,
  output logic      [N-1:0] k,
  output logic      [N-1:0] s,
  output logic      [N-1:0] r
);
  initial begin
    ctrl = SEA_CTRL_IDLE;
    d = '0;
    j = '0;
    k = '0;
    s = '0;
    r = '0;
  end

  // pins change at the falling edge, then rest past the 3-edge sync path
  // so every flop_clk level lasts well over 2 periods
  task automatic put(input sea_ctrl_t c, input logic [N-1:0] nd, nj, nk, ns, nr);
    @(negedge clk_sys);
    ctrl = c;
    d = nd;
    j = nj;
    k = nk;
    s = ns;
    r = nr;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
endmodule
